// ==== include/lss_defines.svh ====
// constants for the long skip and subtract execution block
// Operation
// - inc to acc skip: acc=mem+1, skip on zero
// - taken skip discards prefetch, adds dummy cycle
// - bit form skips when selected bit set
// - byte form rewrites byte, skips if nonzero
// - skip instructions leave all flags unchanged
// - acc minus mem into accumulator, memory kept
// - acc minus mem written back into memory
// - carry cleared on unsigned borrow (mem above acc), else set
// - subtracts update the six arithmetic flags
`ifndef LSS_DEFINES_SVH
`define LSS_DEFINES_SVH
// data and address widths
`define LSS_DW 8
`define LSS_MAW 16
`define LSS_BAW 2
`define LSS_BITW 3
`define LSS_NFLG 6
// register offsets on the plain port
`define LSS_REG_ACC 2'h0
`define LSS_REG_FLAGS 2'h1
`define LSS_REG_STAT 2'h2
// reset values
`define LSS_ACC_RST 8'h00
`define LSS_FLG_RST 6'h00
`define LSS_MEM_RST 8'h00
`define LSS_ADDR_RST 16'h0000
`define LSS_BIT_RST 3'h0
// status register bit positions
`define LSS_SB_BUSY 0
`define LSS_SB_SKIP 1
// arithmetic constants
`define LSS_ONE 8'h01
`define LSS_ZERO 8'h00
`define LSS_NIB_HI 3
`define LSS_MSB 7
`endif

// ==== include/lss_pkg.sv ====
// types shared by the long skip and subtract execution block
`include "lss_defines.svh"
package lss_pkg;
  // instruction group served by the block
  typedef enum logic [2:0] {
    OP_INC_TO_ACC_SKIP_IF_NULL,
    OP_SKIP_IF_NONNULL_BIT,
    OP_SKIP_IF_NONNULL,
    OP_ACC_MINUS_MEM,
    OP_ACC_MINUS_MEM_TO_MEM
  } lss_op_t;
  // command from the sequencer
  typedef struct packed {
    lss_op_t op;
    logic [`LSS_MAW-1:0] addr;
    logic [`LSS_BITW-1:0] bitsel;
  } lss_cmd_t;
  // status flags, msb first matches bit positions 5..0
  typedef struct packed {
    logic multi_byte_null_flag;
    logic signed_borrow_flag;
    logic carry_flag;
    logic half_borrow_inverse_flag;
    logic zero_flag;
    logic signed_range_error_flag;
  } lss_flags_t;
  // answer of the arithmetic unit
  typedef struct packed {
    logic [`LSS_DW-1:0] result;
    logic skip;
    logic wr_mem;
    logic wr_acc;
    logic upd_flags;
    lss_flags_t flags;
  } lss_alu_t;
  // sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC,
    ST_WRITE,
    ST_DUMMY
  } lss_state_t;
  // whole state of the execution module
  typedef struct packed {
    lss_state_t state;
    lss_cmd_t cmd;
    logic [`LSS_DW-1:0] acc;
    lss_flags_t flags;
    logic [`LSS_DW-1:0] wdata;
    logic skip;
    logic last_skip;
    logic done;
    logic [`LSS_DW-1:0] rdata;
  } lss_st_t;
endpackage

// ==== hdl/lss_alu.sv ====
// arithmetic and skip decision for one instruction
`timescale 1ns/1ps
module lss_alu
  import lss_pkg::*;
(
  // operation and operands
  input wire lss_op_t i_op,
  input wire logic [`LSS_BITW-1:0] i_bitsel,
  input wire logic [`LSS_DW-1:0] i_acc,
  input wire logic [`LSS_DW-1:0] i_mem,
  input wire lss_flags_t i_flags,
  // result
  output lss_alu_t o_res
);

  // flags of acc minus mem
  function automatic lss_flags_t sub_flags(input logic [`LSS_DW-1:0] a,
                                           input logic [`LSS_DW-1:0] b);
    logic [`LSS_DW:0] d;
    lss_flags_t f;
    d = {1'b0, a} - {1'b0, b};
    f.signed_range_error_flag = (a[`LSS_MSB] != b[`LSS_MSB]) &&
                                (d[`LSS_MSB] != a[`LSS_MSB]);
    f.zero_flag = (d[`LSS_DW-1:0] == `LSS_ZERO);
    // no borrow out of the low nibble
    f.half_borrow_inverse_flag =
      (a[`LSS_NIB_HI:0] >= b[`LSS_NIB_HI:0]);
    f.carry_flag = ~d[`LSS_DW];
    // signed less-than result
    f.signed_borrow_flag = f.signed_range_error_flag ^ d[`LSS_MSB];
    // single byte operation, chained zero follows zero
    f.multi_byte_null_flag = f.zero_flag;
    return f;
  endfunction

  // decode per operation
  always_comb begin
    o_res = '0;
    o_res.flags = i_flags;
    unique case (i_op)
      OP_INC_TO_ACC_SKIP_IF_NULL: begin
        o_res.result = i_mem + `LSS_ONE;
        o_res.wr_acc = 1'b1;
        o_res.skip = (o_res.result == `LSS_ZERO);
      end
      OP_SKIP_IF_NONNULL_BIT: begin
        o_res.result = i_mem;
        o_res.skip = i_mem[i_bitsel];
      end
      OP_SKIP_IF_NONNULL: begin
        o_res.result = i_mem;
        o_res.wr_mem = 1'b1;
        o_res.skip = (i_mem != `LSS_ZERO);
      end
      OP_ACC_MINUS_MEM: begin
        o_res.result = i_acc - i_mem;
        o_res.wr_acc = 1'b1;
        o_res.upd_flags = 1'b1;
        o_res.flags = sub_flags(i_acc, i_mem);
      end
      OP_ACC_MINUS_MEM_TO_MEM: begin
        o_res.result = i_acc - i_mem;
        o_res.wr_mem = 1'b1;
        o_res.upd_flags = 1'b1;
        o_res.flags = sub_flags(i_acc, i_mem);
      end
      default: begin
        // illegal op code does nothing
        o_res.result = i_mem;
      end
    endcase
  end

endmodule

// ==== hdl/lss_exec.sv ====
// execution unit for long skip and subtract instructions
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module lss_exec
  import lss_pkg::*;
#(
  parameter int DW = `LSS_DW
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // command from the sequencer
  input wire logic i_cmd_valid,
  input wire lss_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_done,
  output logic o_skip,
  output logic o_discard,
  // data memory port
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [`LSS_MAW-1:0] o_mem_addr,
  output logic [`LSS_DW-1:0] o_mem_wdata,
  input wire logic [`LSS_DW-1:0] i_mem_rdata,
  // register port
  input wire logic [`LSS_BAW-1:0] i_reg_addr,
  input wire logic [`LSS_DW-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [`LSS_DW-1:0] o_reg_rdata,
  // accumulator and flags to the rest of the core
  output logic [`LSS_DW-1:0] o_acc,
  output lss_flags_t o_flags
);

  // the datapath is built for bytes only
  generate
    if (DW != `LSS_DW) begin : g_bad_width
      $error("lss_exec supports only byte data width");
    end
  endgenerate

  lss_st_t st_reg; // registered state
  lss_st_t st_next; // next state
  lss_alu_t alu; // arithmetic answer
  logic [`LSS_DW-1:0] stat_word; // status register view

  // arithmetic on the latched command and memory byte
  lss_alu u_alu (
    .i_op(st_reg.cmd.op),
    .i_bitsel(st_reg.cmd.bitsel),
    .i_acc(st_reg.acc),
    .i_mem(i_mem_rdata),
    .i_flags(st_reg.flags),
    .o_res(alu)
  );

  // status register contents
  always_comb begin
    stat_word = '0;
    stat_word[`LSS_SB_BUSY] = (st_reg.state != ST_IDLE);
    stat_word[`LSS_SB_SKIP] = st_reg.last_skip;
  end

  // next state of the whole module
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    // register writes, overridden below by execution
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        // accumulator is software writable
        `LSS_REG_ACC: st_next.acc = i_reg_wdata;
        // flags are software writable
        `LSS_REG_FLAGS: st_next.flags = i_reg_wdata[`LSS_NFLG-1:0];
        // status and unmapped ignore writes
        default: st_next.rdata = st_next.rdata;
      endcase
    end
    // register reads answer one cycle later
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `LSS_REG_ACC: st_next.rdata = st_reg.acc;
        `LSS_REG_FLAGS: st_next.rdata = {2'b00, st_reg.flags};
        `LSS_REG_STAT: st_next.rdata = stat_word;
        default: st_next.rdata = `LSS_ZERO;
      endcase
    end else begin
      // read data stand for one cycle only
      st_next.rdata = `LSS_ZERO;
    end
    // instruction sequencing
    unique case (st_reg.state)
      ST_IDLE: begin
        // take a new command
        if (i_cmd_valid) begin
          st_next.cmd = i_cmd;
          st_next.state = ST_READ;
        end
      end
      ST_READ: begin
        // memory read strobe is up in this cycle
        st_next.state = ST_EXEC;
      end
      ST_EXEC: begin
        // memory byte arrives now
        st_next.skip = alu.skip;
        st_next.last_skip = alu.skip;
        st_next.wdata = alu.result;
        if (alu.wr_acc) begin
          st_next.acc = alu.result;
        end
        if (alu.upd_flags) begin
          st_next.flags = alu.flags;
        end
        if (alu.wr_mem) begin
          st_next.state = ST_WRITE;
        end else if (alu.skip) begin
          st_next.state = ST_DUMMY;
        end else begin
          st_next.state = ST_IDLE;
          st_next.done = 1'b1;
        end
      end
      ST_WRITE: begin
        // memory write strobe is up in this cycle
        if (st_reg.skip) begin
          st_next.state = ST_DUMMY;
        end else begin
          st_next.state = ST_IDLE;
          st_next.done = 1'b1;
        end
      end
      ST_DUMMY: begin
        // prefetched instruction replaced by a dummy
        st_next.state = ST_IDLE;
        st_next.done = 1'b1;
      end
      default: begin
        // unused state codes fall back to idle
        st_next.state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg.state <= ST_IDLE;
      st_reg.cmd.op <= OP_INC_TO_ACC_SKIP_IF_NULL;
      st_reg.cmd.addr <= `LSS_ADDR_RST;
      st_reg.cmd.bitsel <= `LSS_BIT_RST;
      st_reg.acc <= `LSS_ACC_RST;
      st_reg.flags <= `LSS_FLG_RST;
      st_reg.wdata <= `LSS_MEM_RST;
      st_reg.skip <= 1'b0;
      st_reg.last_skip <= 1'b0;
      st_reg.done <= 1'b0;
      st_reg.rdata <= `LSS_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // handshake and strobes decoded from state, done straight from its flop
  assign o_cmd_ready = (st_reg.state == ST_IDLE);
  assign o_mem_rd = (st_reg.state == ST_READ);
  assign o_mem_wr = (st_reg.state == ST_WRITE);
  assign o_discard = (st_reg.state == ST_DUMMY);
  assign o_skip = o_discard;
  assign o_done = st_reg.done;
  // data outputs straight from flops
  assign o_mem_addr = st_reg.cmd.addr;
  assign o_mem_wdata = st_reg.wdata;
  assign o_reg_rdata = st_reg.rdata;
  assign o_acc = st_reg.acc;
  assign o_flags = st_reg.flags;

endmodule

// ==== verif/lss_exec_properties.sv ====
// port assertions for the long skip and subtract unit
`timescale 1ns/1ps
module lss_exec_properties
  import lss_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // command side
  input wire logic i_cmd_valid,
  input wire lss_cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_done,
  input wire logic o_skip,
  input wire logic o_discard,
  // memory side and results
  input wire logic o_mem_rd,
  input wire logic o_mem_wr,
  input wire logic [7:0] o_mem_wdata,
  input wire logic [7:0] i_mem_rdata,
  input wire logic [7:0] o_acc,
  input wire lss_flags_t o_flags
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // op of the instruction in flight
  lss_op_t op_reg;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) op_reg <= OP_ACC_MINUS_MEM;
    else if (i_cmd_valid && o_cmd_ready) op_reg <= i_cmd.op;
  end
  a_take_reads: assert property (o_cmd_ready && i_cmd_valid |=>
    o_mem_rd && !o_cmd_ready) else $error("no read after take");
  a_discard_done: assert property (o_discard |-> o_skip ##1 o_done)
    else $error("discard not followed by done");
  a_rd_to_done: assert property (o_mem_rd |-> ##[2:4] o_done)
    else $error("instruction length wrong");
  a_skip_no_flags: assert property (o_cmd_ready && i_cmd_valid &&
    i_cmd.op inside {OP_INC_TO_ACC_SKIP_IF_NULL, OP_SKIP_IF_NONNULL_BIT,
    OP_SKIP_IF_NONNULL} |=> $stable(o_flags) [*4])
    else $error("skip op changed flags");
  a_inc_skip_zero: assert property (o_done &&
    op_reg == OP_INC_TO_ACC_SKIP_IF_NULL |->
    $past(o_discard) == (o_acc == 8'h00)) else $error("inc skip wrong");
  a_byte_rewrite: assert property (o_mem_wr &&
    op_reg == OP_SKIP_IF_NONNULL |-> o_mem_wdata == $past(i_mem_rdata))
    else $error("byte not written back");
  a_byte_skip: assert property (o_mem_wr &&
    op_reg == OP_SKIP_IF_NONNULL |-> ##1
    o_discard == ($past(o_mem_wdata) != 8'h00)) else $error("byte skip");
  a_sub_mem_value: assert property (o_mem_wr &&
    op_reg == OP_ACC_MINUS_MEM_TO_MEM |->
    o_mem_wdata == o_acc - $past(i_mem_rdata)) else $error("sub to mem");
  a_sub_zero_flag: assert property (o_done &&
    op_reg == OP_ACC_MINUS_MEM |-> o_flags.zero_flag == (o_acc == 8'h00)
    && o_flags.multi_byte_null_flag == o_flags.zero_flag)
    else $error("zero flag wrong");
endmodule
bind lss_exec lss_exec_properties u_props (.i_clk_sys(i_clk_sys),
  .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
  .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_skip(o_skip),
  .o_discard(o_discard), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
  .o_acc(o_acc), .o_flags(o_flags));

// ==== verif/lss_exec_tb.sv ====
// self-checking bench for the long skip and subtract unit
`timescale 1ns/1ps
module lss_exec_tb;
  import lss_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_cmd_valid = 1'b0;
  lss_cmd_t i_cmd = '0;
  logic [7:0] i_mem_rdata = 8'h00;
  logic [1:0] i_reg_addr = 2'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic o_cmd_ready, o_done, o_skip, o_discard, o_mem_rd, o_mem_wr;
  logic [15:0] o_mem_addr;
  logic [7:0] o_mem_wdata, o_reg_rdata, o_acc;
  lss_flags_t o_flags;
  logic [7:0] mval = 8'h00; // byte held by the modelled memory
  int err_total = 0;
  int checks = 0;
  always #10 i_clk_sys = ~i_clk_sys;
  // memory answers only in the cycle after a read
  always @(posedge i_clk_sys) i_mem_rdata <= o_mem_rd ? mval : ~mval;
  lss_exec dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
    .o_done(o_done), .o_skip(o_skip), .o_discard(o_discard),
    .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_acc(o_acc), .o_flags(o_flags));
  // verdict and end of run
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // compare one value
  task automatic cmp(string nm, logic [8:0] e, logic [8:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask
  // one-cycle register write
  task automatic reg_wr(logic [1:0] a, logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  // one-cycle register read, data checked next cycle
  task automatic reg_rd(logic [1:0] a, logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    cmp("reg", {1'b0, e}, {1'b0, o_reg_rdata});
  endtask
  // issue one instruction, watch it to done and judge it
  task automatic run(lss_op_t op, logic [2:0] bs, logic [7:0] mv,
    int nc, logic sk, logic [8:0] wd, logic [7:0] ea, logic [5:0] ef);
    int n;
    logic s;
    logic [8:0] w;
    n = 0;
    s = 1'b0;
    w = 9'h000;
    mval = mv;
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b1;
    i_cmd <= '{op: op, addr: 16'h5a3c, bitsel: bs};
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
    do begin
      @(negedge i_clk_sys);
      n++;
      if (o_discard === 1'b1) s = 1'b1;
      cmp("skip_pin", {8'h00, o_discard}, {8'h00, o_skip});
      if (o_mem_wr === 1'b1) w = {1'b1, o_mem_wdata};
      if (o_mem_rd === 1'b1) cmp("addr", 9'h03c, {1'b0, o_mem_addr[7:0]});
      if (n > 12) begin
        err_total++;
        print_verdict();
      end
    end while (o_done !== 1'b1);
    cmp("cycles", 9'(nc), 9'(n));
    cmp("ready", 9'h001, {8'h00, o_cmd_ready});
    cmp("skip", {8'h00, sk}, {8'h00, s});
    cmp("wdata", wd, w);
    cmp("acc", {1'b0, ea}, {1'b0, o_acc});
    cmp("flags", {3'h0, ef}, {3'h0, o_flags});
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    reg_rd(2'h0, 8'h00);
    reg_rd(2'h1, 8'h00);
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3, 8'h00);
    reg_wr(2'h1, 8'h2a);
    reg_rd(2'h1, 8'h2a);
    run(OP_INC_TO_ACC_SKIP_IF_NULL, 3'h0, 8'hff, 4, 1, 9'h0, 8'h00, 6'h2a);
    run(OP_INC_TO_ACC_SKIP_IF_NULL, 3'h0, 8'h7f, 3, 0, 9'h0, 8'h80, 6'h2a);
    run(OP_SKIP_IF_NONNULL_BIT, 3'h7, 8'h80, 4, 1, 9'h0, 8'h80, 6'h2a);
    run(OP_SKIP_IF_NONNULL_BIT, 3'h0, 8'hfe, 3, 0, 9'h0, 8'h80, 6'h2a);
    run(OP_SKIP_IF_NONNULL, 3'h0, 8'h00, 4, 0, 9'h100, 8'h80, 6'h2a);
    run(OP_SKIP_IF_NONNULL, 3'h0, 8'h01, 5, 1, 9'h101, 8'h80, 6'h2a);
    reg_wr(2'h0, 8'h10);
    run(OP_ACC_MINUS_MEM, 3'h0, 8'h20, 3, 0, 9'h0, 8'hf0, 6'h14);
    reg_wr(2'h0, 8'h80);
    run(OP_ACC_MINUS_MEM, 3'h0, 8'h01, 3, 0, 9'h0, 8'h7f, 6'h19);
    reg_wr(2'h0, 8'h33);
    run(OP_ACC_MINUS_MEM, 3'h0, 8'h33, 3, 0, 9'h0, 8'h00, 6'h2e);
    reg_wr(2'h0, 8'h05);
    run(OP_ACC_MINUS_MEM_TO_MEM, 3'h0, 8'h07, 4, 0, 9'h1fe, 8'h05, 6'h10);
    reg_rd(2'h2, 8'h00);
    print_verdict();
  end
endmodule
